// ==== rtl/temp_fmt_pkg.sv ====
// Package for the temperature result formatting block: map, fields, types.
package temp_fmt_pkg;
   // Register offsets seen by the serial host
   localparam logic [7:0] LOCAL_TEMP_RESULT_ADDR = 8'h00;
   localparam logic [7:0] REMOTE_TEMP_UPPER_ADDR = 8'h01;
   localparam logic [7:0] REMOTE_TEMP_FRACTION_ADDR = 8'h10;
   localparam logic [7:0] CONFIG_RD_ADDR = 8'h03;
   localparam logic [7:0] CONFIG_WR_ADDR = 8'h09;
   localparam logic [7:0] RATE_RD_ADDR = 8'h04;
   localparam logic [7:0] RATE_WR_ADDR = 8'h0a;
   localparam logic [7:0] AUX_BASE_ADDR = 8'h20;
   localparam int AUX_COUNT = 17;
   // Configuration fields
   localparam int CFG_RANGE_BIT = 2;
   localparam int CFG_STANDBY_BIT = 6;
   localparam logic [7:0] CFG_WRITE_MASK = 8'he4;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   // Conversion rate
   localparam logic [7:0] RATE_RESET = 8'h08;
   localparam logic [7:0] RATE_WRITE_MASK = 8'h0f;
   localparam logic [7:0] RATE_FAST_MIN = 8'h08;
   // Formatting constants
   localparam int AVG_SAMPLES = 16;
   localparam int AVG_SHIFT = 4;
   localparam int FRAC_BITS = 2;
   localparam int EXT_OFFSET_DEG = 64;
   localparam int BIN_MAX_DEG = 127;
   localparam int EXT_MAX_CODE = 255;
   localparam int TEMP_W = 12;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // One converter result, quarter degrees, two's complement
   typedef struct packed {
      logic valid;
      logic remote;
      logic diode_short;
      logic signed [TEMP_W-1:0] temp;
   } meas_s;
   // One byte access from the serial side
   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [7:0] data;
   } req_s;
endpackage : temp_fmt_pkg

// ==== rtl/temp_result_format_readout.sv ====
// Temperature result averaging, formatting, storage and host readout.
`timescale 1ns/1ps
module temp_result_format_readout
   import temp_fmt_pkg::*;
(
   // Core clock and reset
   input wire logic clk,
   input wire logic rst,
   // Converter results, core domain
   input wire meas_s meas,
   // Control to the converter
   output logic standby,
   output logic [3:0] rate_code,
   // Serial side, link domain
   input wire logic link_clk,
   input wire logic req_valid,
   input wire req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data
);
   ////////////////////////////////////////////////////////////////////////
   // Link domain
   logic [1:0] lrst_sync_reg; // Reset carried into link domain
   logic link_rst;
   logic req_tgl_reg; // Event toggle toward core
   req_s req_hold_reg; // Held stable until answered
   logic [1:0] ack_sync_reg; // Answer toggle synchroniser
   logic ack_seen_reg; // Last answer toggle handled
   logic busy_reg; // Request outstanding
   logic req_ready_reg;
   logic rsp_valid_reg;
   logic [7:0] rsp_data_reg;
   // Core domain
   logic [2:0] req_sync_reg; // Two stages plus edge history
   logic req_pulse;
   logic ack_tgl_reg; // Answer event toggle
   logic [7:0] rd_data_reg; // Read data, stable across crossing
   logic [7:0] config_reg;
   logic [7:0] rate_reg;
   logic [7:0] aux_reg [AUX_COUNT]; // Limits and other plain bytes
   logic [7:0] local_reg;
   logic [7:0] remote_hi_reg;
   logic [7:0] remote_lo_reg;
   logic lock_reg; // Remote high byte frozen
   logic signed [TEMP_W+3:0] acc_reg [2]; // Per channel sums
   logic [3:0] cnt_reg [2]; // Per channel sample counts
   logic standby_reg;
   logic [3:0] rate_code_reg;

   // Reset synchroniser, released on link clock
   always_ff @(posedge link_clk) begin
      lrst_sync_reg <= {lrst_sync_reg[0], rst};
   end
   assign link_rst = lrst_sync_reg[1];

   // Capture request, raise event, wait for answer
   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         req_tgl_reg <= 1'b0;
         req_hold_reg <= '0;
         ack_sync_reg <= 2'b00;
         ack_seen_reg <= 1'b0;
         busy_reg <= 1'b0;
         req_ready_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 8'h00;
      end else begin
         ack_sync_reg <= {ack_sync_reg[0], ack_tgl_reg};
         rsp_valid_reg <= 1'b0;
         if (!busy_reg && req_ready_reg && req_valid) begin
            // New access taken
            req_hold_reg <= req;
            req_tgl_reg <= ~req_tgl_reg;
            busy_reg <= 1'b1;
            req_ready_reg <= 1'b0;
         end else if (busy_reg && ack_sync_reg[1] != ack_seen_reg) begin
            // Core answered; read data held stable by core
            ack_seen_reg <= ack_sync_reg[1];
            rsp_data_reg <= rd_data_reg;
            rsp_valid_reg <= 1'b1;
            busy_reg <= 1'b0;
            req_ready_reg <= 1'b1;
         end else if (!busy_reg) begin
            req_ready_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core domain crossing
   always_ff @(posedge clk) begin
      if (rst) begin
         req_sync_reg <= 3'b000;
      end else begin
         req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
      end
   end
   assign req_pulse = req_sync_reg[2] ^ req_sync_reg[1];

   // Decoded host accesses; hold register is stable while busy
   logic host_wr;
   logic host_rd;
   assign host_wr = req_pulse && req_hold_reg.write;
   assign host_rd = req_pulse && !req_hold_reg.write;

   // Read mux and answer toggle
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_reg <= 8'h00;
         ack_tgl_reg <= 1'b0;
      end else if (req_pulse) begin
         ack_tgl_reg <= ~ack_tgl_reg;
         rd_data_reg <= UNMAPPED_READ;
         if (!req_hold_reg.write) begin
            unique case (req_hold_reg.addr)
               LOCAL_TEMP_RESULT_ADDR: rd_data_reg <= local_reg;
               REMOTE_TEMP_UPPER_ADDR: rd_data_reg <= remote_hi_reg;
               REMOTE_TEMP_FRACTION_ADDR: rd_data_reg <= remote_lo_reg;
               CONFIG_RD_ADDR: rd_data_reg <= config_reg;
               RATE_RD_ADDR: rd_data_reg <= rate_reg;
               default: begin
                  if (req_hold_reg.addr >= AUX_BASE_ADDR &&
                      req_hold_reg.addr < AUX_BASE_ADDR + 8'(AUX_COUNT)) begin
                     rd_data_reg <= aux_reg[5'(req_hold_reg.addr - AUX_BASE_ADDR)];
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Writable registers; results have no write path
   always_ff @(posedge clk) begin
      if (rst) begin
         config_reg <= CONFIG_RESET;
         rate_reg <= RATE_RESET;
         for (int i = 0; i < AUX_COUNT; i++) begin
            aux_reg[i] <= 8'h00;
         end
      end else if (host_wr) begin
         // Writes to 0x00, 0x01, 0x10 fall through untouched
         if (req_hold_reg.addr == CONFIG_WR_ADDR) begin
            config_reg <= req_hold_reg.data & CFG_WRITE_MASK;
         end else if (req_hold_reg.addr == RATE_WR_ADDR) begin
            rate_reg <= req_hold_reg.data & RATE_WRITE_MASK;
         end else if (req_hold_reg.addr >= AUX_BASE_ADDR &&
                      req_hold_reg.addr < AUX_BASE_ADDR + 8'(AUX_COUNT)) begin
            // Limits stored as written, never reformatted
            aux_reg[5'(req_hold_reg.addr - AUX_BASE_ADDR)] <= req_hold_reg.data;
         end
      end
   end

   // Converter controls from registers
   always_ff @(posedge clk) begin
      if (rst) begin
         standby_reg <= 1'b0;
         rate_code_reg <= RATE_RESET[3:0];
      end else begin
         standby_reg <= config_reg[CFG_STANDBY_BIT];
         rate_code_reg <= rate_reg[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Averaging
   logic fast; // No averaging at 16, 32, 64 per second
   logic ch; // Channel of the current sample
   logic take; // Sample accepted
   logic fire; // Result ready this cycle
   logic signed [TEMP_W+3:0] sum;
   logic signed [TEMP_W-1:0] avg;
   assign fast = rate_reg >= RATE_FAST_MIN;
   assign ch = meas.remote;
   assign take = meas.valid && !(meas.remote && meas.diode_short);
   assign sum = acc_reg[ch] + (TEMP_W+4)'(meas.temp);
   assign fire = take && (fast || cnt_reg[ch] == 4'(AVG_SAMPLES - 1));
   assign avg = fast ? meas.temp : TEMP_W'(sum >>> AVG_SHIFT);

   // Accumulators restart after each reported average
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 2; i++) begin
            acc_reg[i] <= '0;
            cnt_reg[i] <= 4'h0;
         end
      end else if (take) begin
         if (fire) begin
            acc_reg[ch] <= '0;
            cnt_reg[ch] <= 4'h0;
         end else begin
            acc_reg[ch] <= sum;
            cnt_reg[ch] <= cnt_reg[ch] + 4'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Formatting: range bit read at store time, so next result is new format
   logic ext; // Extended range selected
   logic signed [TEMP_W-1:0] deg; // Whole degrees, floored
   logic signed [TEMP_W-1:0] code; // Offset applied
   logic [7:0] hi_byte;
   logic [7:0] lo_byte;
   assign ext = config_reg[CFG_RANGE_BIT];
   assign deg = avg >>> FRAC_BITS;
   assign code = ext ? deg + TEMP_W'(EXT_OFFSET_DEG) : deg;
   always_comb begin
      hi_byte = code[7:0];
      lo_byte = {avg[1:0], 6'b000000};
      if (code < 0) begin
         hi_byte = 8'h00;
         lo_byte = 8'h00;
      end else if (!ext && code > TEMP_W'(BIN_MAX_DEG)) begin
         hi_byte = 8'(BIN_MAX_DEG);
         lo_byte = 8'h00;
      end else if (ext && code > TEMP_W'(EXT_MAX_CODE)) begin
         hi_byte = 8'(EXT_MAX_CODE);
         lo_byte = 8'h00;
      end
   end

   // Result registers, written only by the converter path
   always_ff @(posedge clk) begin
      if (rst) begin
         local_reg <= RESULT_RESET;
         remote_hi_reg <= RESULT_RESET;
         remote_lo_reg <= RESULT_RESET;
      end else if (fire) begin
         if (!ch) begin
            local_reg <= hi_byte;
         end else begin
            remote_lo_reg <= lo_byte;
            if (!lock_reg) begin
               remote_hi_reg <= hi_byte;
            end
         end
      end
   end

   // High byte lock; a high-byte read alone never sets it
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_reg <= 1'b0;
      end else if (host_rd && req_hold_reg.addr == REMOTE_TEMP_FRACTION_ADDR) begin
         lock_reg <= 1'b1;
      end else if (host_rd && req_hold_reg.addr == REMOTE_TEMP_UPPER_ADDR) begin
         lock_reg <= 1'b0;
      end
   end

   // Outputs
   assign standby = standby_reg;
   assign rate_code = rate_code_reg;
   assign req_ready = req_ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data = rsp_data_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   lock_hold_a: assert property (lock_reg && !host_rd |=> $stable(remote_hi_reg))
      else $error("remote high byte changed while locked");
   lock_set_a: assert property (
      host_rd && req_hold_reg.addr == REMOTE_TEMP_FRACTION_ADDR |=> lock_reg)
      else $error("fraction read did not lock");
   lock_hi_only_a: assert property (
      !lock_reg && host_rd && req_hold_reg.addr == REMOTE_TEMP_UPPER_ADDR |=> !lock_reg)
      else $error("high byte read created a lock");
   frac_low_a: assert property (remote_lo_reg[5:0] == 6'h00)
      else $error("fraction low bits not zero");
   bin_clamp_a: assert property (fire && !ch && !ext |=> local_reg <= 8'h7f)
      else $error("binary result above clamp");
   short_keep_a: assert property (
      meas.valid && meas.remote && meas.diode_short && !(host_wr || host_rd)
      |=> $stable(remote_hi_reg) && $stable(remote_lo_reg))
      else $error("shorted diode changed remote result");
   fast_direct_a: assert property (
      fast && meas.valid && !meas.remote |=> $past(fire))
      else $error("fast rate sample not reported");
   avg_wait_a: assert property (
      !fast && take && cnt_reg[ch] != 4'hf |-> !fire)
      else $error("average reported early");
   ext_offset_a: assert property (
      ext && fast && meas.valid && !meas.remote && meas.temp == '0
      |=> local_reg == 8'h40)
      else $error("extended zero not offset by 64");
   range_wr_a: assert property (
      host_wr && req_hold_reg.addr == CONFIG_WR_ADDR
      |=> config_reg[CFG_RANGE_BIT] == $past(req_hold_reg.data[CFG_RANGE_BIT]))
      else $error("range bit not taken from write");
   ro_result_a: assert property (
      host_wr && req_hold_reg.addr == LOCAL_TEMP_RESULT_ADDR && !fire
      |=> $stable(local_reg))
      else $error("host write changed local result");
   // Reset itself is the antecedent, so the default disable must not apply here
   rate_reset_a: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> rate_reg == RATE_RESET)
      else $error("rate not at default after reset");
endmodule : temp_result_format_readout

// ==== test/host_model.sv ====
// Serial host model issuing one byte access at a time on the link side.
`timescale 1ns/1ps
module host_model
   import temp_fmt_pkg::*;
(
   // Link clock
   input wire logic link_clk,
   // Access request
   output logic req_valid,
   output req_s req,
   input wire logic req_ready,
   // Response
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data
);
   // Idle request lines start low
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One access; q stays unknown if the device never answers, so a hang shows up
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
         output logic [7:0] q);
      int n;
      n = 0;
      q = 8'hxx;
      @(posedge link_clk);
      #1;
      req_valid = 1'b1;
      req = '{write: wr, addr: addr, data: data};
      // Hold everything until ready is seen ahead of a rising edge
      while (req_ready !== 1'b1 && n < 300) begin
         @(negedge link_clk);
         n++;
      end
      @(posedge link_clk);
      #1;
      req_valid = 1'b0;
      // Released lines carry the inverse, never a stale copy
      req = ~req;
      n = 0;
      // Response pulse lasts one link cycle, so look every cycle
      while (n < 300) begin
         @(negedge link_clk);
         n++;
         if (rsp_valid === 1'b1) begin
            q = rsp_data;
            break;
         end
      end
   endtask : access
endmodule : host_model

// ==== test/tb.sv ====
// Self-checking bench for the temperature result formatting block.
`timescale 1ns/1ps
module tb
   import temp_fmt_pkg::*;
;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   meas_s meas = '0;
   logic standby, req_valid, req_ready, rsp_valid;
   logic [3:0] rate_code;
   logic [7:0] rsp_data, q, rv;
   req_s req;
   int miscompares = 0;
   int checks = 0;
   int seed = 32'h9835bdbd;
   // Reference model state
   logic [7:0] exp_local, exp_hi, exp_frac;
   logic locked, fast, ext;
   int cnt [2];
   int sum [2];
   ////////////////////////////////////////////////////////////////////////////////
   // Core at 100 ns, link at 12 ns with an unrelated phase
   always #50 clk = ~clk;
   initial #3 forever #6 link_clk = ~link_clk;
   temp_result_format_readout i_dut (.clk(clk), .rst(rst), .meas(meas), .standby(standby),
      .rate_code(rate_code), .link_clk(link_clk), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   host_model i_host (.link_clk(link_clk), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   ////////////////////////////////////////////////////////////////////////////////
   // Expected high byte and fraction byte for quarter-degree value t
   function automatic logic [15:0] fmt(input int t);
      int d, lim;
      d = (t >>> 2) + (ext ? 64 : 0);
      lim = ext ? 255 : 127;
      if (d < 0) return 16'h0000;
      if (d > lim) return {lim[7:0], 8'h00};
      return {d[7:0], t[1:0], 6'h00};
   endfunction : fmt
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Host read compared with the model; tracks the high-byte lock
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      i_host.access(1'b0, a, 8'h00, r);
      if (a == 8'h10) locked = 1'b1;
      if (a == 8'h01) locked = 1'b0;
      check(r, e);
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.access(1'b1, a, d, q);
   endtask : wr
   // One converter sample, then the model's view of what gets stored
   task automatic feed(input logic rm, input logic sh, input logic [11:0] t);
      int c;
      logic [15:0] f;
      c = rm;
      @(negedge clk);
      meas = '{valid: 1'b1, remote: rm, diode_short: sh, temp: t};
      @(negedge clk);
      meas.valid = 1'b0;
      if (rm && sh) return;
      if (fast) f = fmt($signed(t));
      else begin
         cnt[c]++;
         sum[c] += $signed(t);
         if (cnt[c] < 16) return;
         f = fmt(sum[c] >>> 4);
         cnt[c] = 0;
         sum[c] = 0;
      end
      if (rm) begin
         exp_frac = f[7:0];
         if (!locked) exp_hi = f[15:8];
      end else exp_local = f[15:8];
   endtask : feed
   task automatic do_reset();
      rst = 1'b1;
      {exp_local, exp_hi, exp_frac, locked, ext} = '0;
      fast = 1'b1;
      cnt = '{0, 0};
      sum = '{0, 0};
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
   endtask : do_reset
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog well beyond the expected run
   initial begin
      #3_000_000;
      miscompares++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      do_reset();
      foreach (cnt[i]) chk(i ? 8'h01 : 8'h00, 8'h00);
      chk(8'h10, 8'h00);
      chk(8'h03, 8'h00);
      chk(8'h04, 8'h08);
      check({3'h0, standby, rate_code}, 8'h08);
      // Slow rate straight after reset, so the averages start empty
      wr(8'h0a, 8'h04);
      fast = 1'b0;
      // Control outputs follow the register one core cycle after the write lands
      repeat (2) @(negedge clk);
      check({4'h0, rate_code}, 8'h04);
      for (int i = 0; i < 16; i++) begin
         feed(1'b0, 1'b0, 12'($random(seed) % 600));
         if (i >= 14) chk(8'h00, exp_local);
      end
      // Fast codes 8 to 10 each report every sample
      for (int c = 8; c <= 10; c++) begin
         wr(8'h0a, 8'(c));
         fast = 1'b1;
         repeat (2) @(negedge clk);
         check({4'h0, rate_code}, 8'(c));
         feed(1'b0, 1'b0, 12'($random(seed)));
         chk(8'h00, exp_local);
      end
      // Full-range remote values, low byte first for a coherent pair
      repeat (8) begin
         feed(1'b1, 1'b0, 12'($random(seed)));
         chk(8'h10, exp_frac);
         chk(8'h01, exp_hi);
      end
      chk(8'h10, exp_frac);
      feed(1'b1, 1'b0, 12'($random(seed)));
      chk(8'h10, exp_frac);
      chk(8'h01, exp_hi);
      feed(1'b1, 1'b0, 12'($random(seed)));
      chk(8'h01, exp_hi);
      feed(1'b1, 1'b1, 12'h1ff);
      chk(8'h10, exp_frac);
      chk(8'h01, exp_hi);
      // Result registers are read only; unmapped reads give zero
      wr(8'h00, 8'hff);
      wr(8'h01, 8'hff);
      wr(8'h11, 8'hff);
      chk(8'h00, exp_local);
      chk(8'h01, exp_hi);
      chk(8'h11, 8'h00);
      rv = 8'($random(seed));
      wr(8'h20, rv);
      wr(8'h30, ~rv);
      chk(8'h30, ~rv);
      // Extended range; limit bytes must survive untouched
      wr(8'h09, 8'h44);
      repeat (2) @(negedge clk);
      check({7'h0, standby}, 8'h01);
      wr(8'h09, 8'h04);
      ext = 1'b1;
      chk(8'h03, 8'h04);
      chk(8'h20, rv);
      // Zero degrees right after the switch must already read as offset 64
      feed(1'b0, 1'b0, 12'h000);
      chk(8'h00, exp_local);
      feed(1'b0, 1'b0, 12'hd80);
      chk(8'h00, exp_local);
      repeat (6) begin
         feed(1'b1, 1'b0, 12'($random(seed) % 700));
         feed(1'b0, 1'b0, 12'($random(seed)));
         chk(8'h10, exp_frac);
         chk(8'h01, exp_hi);
         chk(8'h00, exp_local);
      end
      tally_and_finish();
   end
endmodule : tb
